/* File: dhi_pkg.sv */
// Shared constants, types and helpers for the display host interface.
package dhi_pkg;
  localparam int CLK_MHZ = 100;
  localparam int WORD_W = 18;
  localparam int POS_W = 9;
  localparam int FIFO_DEPTH = 8;
  localparam int SER3_BITS = 9;
  localparam int SER4_BITS = 8;
  localparam int SER_W = 8;
  localparam int H_ACTIVE = 320;
  localparam int V_ACTIVE = 480;
  localparam int H_PORCH_MIN = 3;
  localparam int V_PORCH_MIN = 2;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int RST_REJECT_NS = 5000;
  localparam int RST_REJECT_CYC = (RST_REJECT_NS * CLK_MHZ + 999) / 1000;
  localparam int RST_FULL_NS = 9000;
  localparam int RST_FULL_CYC = (RST_FULL_NS * CLK_MHZ) / 1000;
  localparam int LOAD_MS = 5;
  localparam int LOAD_CYC = LOAD_MS * CLK_MHZ * 1000;
  localparam int BLANK_MS = 120;
  localparam int BLANK_CYC = BLANK_MS * CLK_MHZ * 1000;
  localparam int BUS_HALF_NS = 80;
  localparam int BUS_HALF_CYC = (BUS_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam int PCLK_HALF_NS = 40;
  localparam int PCLK_HALF_CYC = (PCLK_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 24;
  localparam int FLT_W = 10;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    IF_PAR18 = 3'h0,
    IF_PAR9 = 3'h1,
    IF_PAR16 = 3'h2,
    IF_PAR8 = 3'h3,
    IF_SER3 = 3'h5,
    IF_SER4 = 3'h7
  } dhi_mode_e;
  typedef enum logic [1:0] {
    RS_RUN = 2'h0,
    RS_HELD = 2'h1,
    RS_LOAD = 2'h3
  } dhi_rst_e;
  typedef enum logic [1:0] {
    HS_IDLE = 2'h0,
    HS_LOW = 2'h1,
    HS_HIGH = 2'h3,
    HS_END = 2'h2
  } dhi_hst_e;
  typedef struct packed {
    logic rst_n;
    logic cs_n;
    logic dc;
    logic wr_n;
    logic rd_n;
    logic sda;
    logic pclk;
    logic hs_n;
    logic vs_n;
    logic de;
    logic [2:0] strap;
    logic [WORD_W-1:0] db;
  } dhi_pins_s;
  localparam dhi_pins_s PINS_IDLE = '{de: 1'b0, strap: 3'h0, db: '0, default: 1'b1};
  // Active lanes per strap code; unused lanes read and drive as zero
  function automatic logic [WORD_W-1:0] width_mask(input logic [2:0] s);
    unique case (s)
      IF_PAR18: width_mask = 18'h3FFFF;
      IF_PAR9: width_mask = 18'h001FF;
      IF_PAR16: width_mask = 18'h0FFFF;
      IF_PAR8: width_mask = 18'h000FF;
      default: width_mask = 18'h00000;
    endcase
  endfunction
endpackage

/* File: dhi_if.sv */
// Pin-level link between the display host and the panel front end.
`timescale 1ns/1ps
interface dhi_if;
  logic iface_strap_bit0;
  logic iface_strap_bit1;
  logic iface_strap_bit2;
  logic hw_reset_in_n;
  logic chip_select_n;
  logic data_command_select;
  logic write_strobe_n;
  logic read_strobe_n;
  logic serial_data_in;
  logic pixel_clock_in;
  logic hsync_n;
  logic vsync_n;
  logic data_enable;
  logic [dhi_pkg::WORD_W-1:0] host_db_o;
  logic host_db_oe;
  logic [dhi_pkg::WORD_W-1:0] dev_db_o;
  logic dev_db_oe;
  logic [dhi_pkg::WORD_W-1:0] parallel_data_bus;
  logic serial_read_o;
  logic serial_read_oe;
  logic serial_read_out;
  // Undriven bus lanes settle low
  assign parallel_data_bus = host_db_oe ? host_db_o : (dev_db_oe ? dev_db_o : '0);
  assign serial_read_out = serial_read_oe & serial_read_o;
  modport host (
    output iface_strap_bit0, iface_strap_bit1, iface_strap_bit2, hw_reset_in_n,
    output chip_select_n, data_command_select, write_strobe_n, read_strobe_n,
    output serial_data_in, pixel_clock_in, hsync_n, vsync_n, data_enable,
    output host_db_o, host_db_oe,
    input parallel_data_bus, serial_read_out
  );
  modport dev (
    input iface_strap_bit0, iface_strap_bit1, iface_strap_bit2, hw_reset_in_n,
    input chip_select_n, data_command_select, write_strobe_n, read_strobe_n,
    input serial_data_in, pixel_clock_in, hsync_n, vsync_n, data_enable,
    input parallel_data_bus,
    output dev_db_o, dev_db_oe, serial_read_o, serial_read_oe
  );
endinterface

/* File: dhi_fifo.sv */
// Synchronous valid/ready FIFO.
`timescale 1ns/1ps
module dhi_fifo #(
  parameter int W = 19,
  parameter int DEPTH = 8
) (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [W-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [W-1:0] o_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wp_r, rp_r;
  logic push, pop;

  assign o_ready = (wp_r[AW] == rp_r[AW]) || (wp_r[AW-1:0] != rp_r[AW-1:0]);
  assign o_valid = wp_r != rp_r;
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;
  assign o_data = mem[rp_r[AW-1:0]];

  always_ff @(posedge i_clock)
  begin
    if (push)
      mem[wp_r[AW-1:0]] <= i_data;
  end

  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      wp_r <= '0;
      rp_r <= '0;
    end
    else
    begin
      if (push)
        wp_r <= wp_r + 1'b1;
      if (pop)
        rp_r <= rp_r + 1'b1;
    end
  end
endmodule // dhi_fifo

/* File: dhi_dev.sv */
// Panel end: strap decode, bus and serial receive, RGB capture, reset filter.
`timescale 1ns/1ps
module dhi_dev #(
  parameter int LOAD_CYCLES = dhi_pkg::LOAD_CYC,
  parameter int BLANK_CYCLES = dhi_pkg::BLANK_CYC,
  parameter int DEPTH = dhi_pkg::FIFO_DEPTH
) (
  input wire logic I_CLOCK,
  input wire logic I_RESET,
  dhi_if.dev link,
  input wire logic I_AWAKE,
  input wire logic I_SER_RD,
  input wire logic [dhi_pkg::WORD_W-1:0] I_RD_DATA,
  output logic O_RD_STROBE,
  output logic O_WORD_VALID,
  input wire logic I_WORD_READY,
  output logic [dhi_pkg::WORD_W-1:0] O_WORD_DATA,
  output logic O_WORD_IS_DATA,
  output logic O_OVERFLOW,
  output logic O_BLANK,
  output logic O_READY,
  output logic O_PIX_VALID,
  output logic [dhi_pkg::WORD_W-1:0] O_PIX_DATA,
  output logic [dhi_pkg::POS_W-1:0] O_PIX_COL,
  output logic [dhi_pkg::POS_W-1:0] O_PIX_ROW
);
  import dhi_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  dhi_pins_s raw, s1_r, s2_r, s3_r;
  assign raw = {link.hw_reset_in_n, link.chip_select_n, link.data_command_select,
    link.write_strobe_n, link.read_strobe_n, link.serial_data_in, link.pixel_clock_in,
    link.hsync_n, link.vsync_n, link.data_enable,
    link.iface_strap_bit2, link.iface_strap_bit1, link.iface_strap_bit0,
    link.parallel_data_bus};

  always_ff @(posedge I_CLOCK)
  begin
    if (I_RESET)
    begin
      s1_r <= PINS_IDLE;
      s2_r <= PINS_IDLE;
      s3_r <= PINS_IDLE;
    end
    else
    begin
      s1_r <= raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  dhi_rst_e st_r;
  logic run, cs_act, par, ser3, ser4, wr_rise, wr_fall, rd_fall, cs_fall, pclk_rise;
  assign run = st_r == RS_RUN;
  assign cs_act = run && !s2_r.cs_n;
  assign par = !s2_r.strap[2];
  assign ser3 = s2_r.strap == IF_SER3;
  assign ser4 = s2_r.strap == IF_SER4;
  assign wr_rise = s2_r.wr_n && !s3_r.wr_n;
  assign wr_fall = !s2_r.wr_n && s3_r.wr_n;
  assign rd_fall = !s2_r.rd_n && s3_r.rd_n;
  assign cs_fall = !s2_r.cs_n && s3_r.cs_n;
  assign pclk_rise = s2_r.pclk && !s3_r.pclk;

  // ----------------------------------------------------------------
  // Reset filter and sequencing
  // ----------------------------------------------------------------
  // Level must hold for the reject time in either direction, so both
  // short low spikes and short high glitches inside a reset are dropped.
  logic filt_r;
  logic [FLT_W-1:0] flt_cnt_r;
  always_ff @(posedge I_CLOCK)
  begin
    if (I_RESET)
    begin
      filt_r <= 1'b1;
      flt_cnt_r <= '0;
    end
    else if (s2_r.rst_n == filt_r)
      flt_cnt_r <= '0;
    else if (flt_cnt_r == FLT_W'(RST_REJECT_CYC - 1))
    begin
      filt_r <= s2_r.rst_n;
      flt_cnt_r <= '0;
    end
    else
      flt_cnt_r <= flt_cnt_r + 1'b1;
  end

  logic [CNT_W-1:0] ld_cnt_r, blank_cnt_r;
  always_ff @(posedge I_CLOCK)
  begin
    if (I_RESET)
    begin
      st_r <= RS_LOAD;
      ld_cnt_r <= CNT_W'(LOAD_CYCLES - 1);
    end
    else
    begin
      unique case (st_r)
        RS_RUN:
          if (!filt_r)
            st_r <= RS_HELD;
        RS_HELD:
          if (filt_r)
          begin
            st_r <= RS_LOAD;
            ld_cnt_r <= CNT_W'(LOAD_CYCLES - 1);
          end
        RS_LOAD:
          if (!filt_r)
            st_r <= RS_HELD;
          else if (ld_cnt_r == '0)
            st_r <= RS_RUN;
          else
            ld_cnt_r <= ld_cnt_r - 1'b1;
        default:
          st_r <= RS_HELD;
      endcase
    end
  end

  // Blanking runs from a reset start seen while awake; asleep keeps it blank regardless
  always_ff @(posedge I_CLOCK)
  begin
    if (I_RESET)
    begin
      blank_cnt_r <= '0;
      O_BLANK <= 1'b1;
      O_READY <= 1'b0;
    end
    else
    begin
      if (run && !filt_r && I_AWAKE)
        blank_cnt_r <= CNT_W'(BLANK_CYCLES);
      else if (blank_cnt_r != '0)
        blank_cnt_r <= blank_cnt_r - 1'b1;
      O_BLANK <= !run || (blank_cnt_r != '0) || !I_AWAKE;
      O_READY <= run;
    end
  end

  // ----------------------------------------------------------------
  // Write capture, parallel and serial
  // ----------------------------------------------------------------
  logic push_r, wdc_r, fin_rdy;
  logic [WORD_W-1:0] wd_r;
  logic [SER_W-1:0] sh_r;
  logic [3:0] bit_cnt_r, nbits;
  assign nbits = ser3 ? 4'(SER3_BITS) : 4'(SER4_BITS);

  always_ff @(posedge I_CLOCK)
  begin
    if (I_RESET || !run)
    begin
      push_r <= 1'b0;
      wdc_r <= 1'b0;
      wd_r <= '0;
      sh_r <= '0;
      bit_cnt_r <= '0;
    end
    else
    begin
      push_r <= 1'b0;
      if (!cs_act)
        bit_cnt_r <= '0;
      else if (par && wr_rise)
      begin
        push_r <= 1'b1;
        wd_r <= s2_r.db & width_mask(s2_r.strap);
        wdc_r <= s2_r.dc;
      end
      else if ((ser3 || ser4) && wr_rise && !I_SER_RD)
      begin
        sh_r <= {sh_r[SER_W-2:0], s2_r.sda};
        if (bit_cnt_r == nbits - 4'h1)
        begin
          push_r <= 1'b1;
          bit_cnt_r <= '0;
          wd_r <= WORD_W'({sh_r[SER_W-2:0], s2_r.sda});
          wdc_r <= ser3 ? sh_r[SER_W-1] : s2_r.dc;
        end
        else
          bit_cnt_r <= bit_cnt_r + 4'h1;
      end
    end
  end

  // Pins cannot be stalled: a word arriving on a full queue is dropped
  always_ff @(posedge I_CLOCK)
  begin
    if (I_RESET)
      O_OVERFLOW <= 1'b0;
    else
      O_OVERFLOW <= push_r && !fin_rdy;
  end

  dhi_fifo #(
    .W(WORD_W + 1),
    .DEPTH(DEPTH)
  ) u_fifo (
    .i_clock(I_CLOCK),
    .i_reset(I_RESET || !run),
    .i_valid(push_r),
    .o_ready(fin_rdy),
    .i_data({wdc_r, wd_r}),
    .o_valid(O_WORD_VALID),
    .i_ready(I_WORD_READY),
    .o_data({O_WORD_IS_DATA, O_WORD_DATA})
  );

  // ----------------------------------------------------------------
  // Read return
  // ----------------------------------------------------------------
  logic [SER_W-1:0] sdo_r;
  always_ff @(posedge I_CLOCK)
  begin
    if (I_RESET)
    begin
      link.dev_db_o <= '0;
      link.dev_db_oe <= 1'b0;
      link.serial_read_oe <= 1'b0;
      sdo_r <= '0;
      O_RD_STROBE <= 1'b0;
    end
    else
    begin
      link.dev_db_oe <= par && cs_act && !s2_r.rd_n;
      link.dev_db_o <= I_RD_DATA & width_mask(s2_r.strap);
      link.serial_read_oe <= (ser3 || ser4) && cs_act && I_SER_RD;
      O_RD_STROBE <= cs_act && ((par && rd_fall) || (!par && cs_fall && I_SER_RD));
      if (cs_fall)
        sdo_r <= I_RD_DATA[SER_W-1:0];
      else if (cs_act && wr_fall && !s3_r.cs_n)
        sdo_r <= {sdo_r[SER_W-2:0], 1'b0};
    end
  end
  assign link.serial_read_o = sdo_r[SER_W-1];

  // ----------------------------------------------------------------
  // RGB pixel capture
  // ----------------------------------------------------------------
  logic [POS_W-1:0] col_r, row_r;
  logic hs_prev_r, had_r;
  always_ff @(posedge I_CLOCK)
  begin
    if (I_RESET || !run)
    begin
      col_r <= '0;
      row_r <= '0;
      hs_prev_r <= 1'b1;
      had_r <= 1'b0;
      O_PIX_VALID <= 1'b0;
      O_PIX_DATA <= '0;
      O_PIX_COL <= '0;
      O_PIX_ROW <= '0;
    end
    else
    begin
      O_PIX_VALID <= 1'b0;
      if (pclk_rise)
      begin
        hs_prev_r <= s2_r.hs_n;
        if (!s2_r.vs_n)
        begin
          row_r <= '0;
          col_r <= '0;
          had_r <= 1'b0;
        end
        else if (!s2_r.hs_n)
        begin
          col_r <= '0;
          if (hs_prev_r && had_r)
          begin
            row_r <= row_r + 1'b1;
            had_r <= 1'b0;
          end
        end
        else if (s2_r.de && col_r < POS_W'(H_ACTIVE) && row_r < POS_W'(V_ACTIVE))
        begin
          O_PIX_VALID <= 1'b1;
          O_PIX_DATA <= s2_r.db;
          O_PIX_COL <= col_r;
          O_PIX_ROW <= row_r;
          col_r <= col_r + 1'b1;
          had_r <= 1'b1;
        end
      end
    end
  end
endmodule // dhi_dev

/* File: dhi_host.sv */
// Host end: bus and serial transfers, RGB timing, reset and strap drive.
`timescale 1ns/1ps
module dhi_host #(
  parameter int HS_CLKS = dhi_pkg::H_PORCH_MIN,
  parameter int HBP_CLKS = dhi_pkg::H_PORCH_MIN,
  parameter int HFP_CLKS = dhi_pkg::H_PORCH_MIN,
  parameter int VS_LINES = dhi_pkg::V_PORCH_MIN,
  parameter int VBP_LINES = dhi_pkg::V_PORCH_MIN,
  parameter int VFP_LINES = dhi_pkg::V_PORCH_MIN
) (
  input wire logic I_CLOCK,
  input wire logic I_RESET,
  dhi_if.host link,
  input wire logic [2:0] I_STRAP,
  input wire logic I_HW_RESET_N,
  input wire logic I_CMD_VALID,
  output logic O_CMD_READY,
  input wire logic I_CMD_READ,
  input wire logic I_CMD_DC,
  input wire logic [dhi_pkg::WORD_W-1:0] I_CMD_DATA,
  output logic O_RSP_VALID,
  output logic [dhi_pkg::WORD_W-1:0] O_RSP_DATA,
  input wire logic I_RGB_EN,
  input wire logic [dhi_pkg::WORD_W-1:0] I_PIX_DATA,
  output logic O_PIX_TAKEN
);
  import dhi_pkg::*;
  localparam int H_TOT = HS_CLKS + HBP_CLKS + H_ACTIVE + HFP_CLKS;
  localparam int V_TOT = VS_LINES + VBP_LINES + V_ACTIVE + VFP_LINES;
  localparam int H_DE0 = HS_CLKS + HBP_CLKS;
  localparam int V_DE0 = VS_LINES + VBP_LINES;

  logic [WORD_W-1:0] db_s1_r, db_s2_r;
  logic sdo_s1_r, sdo_s2_r;
  always_ff @(posedge I_CLOCK)
  begin
    db_s1_r <= link.parallel_data_bus;
    db_s2_r <= db_s1_r;
    sdo_s1_r <= link.serial_read_out;
    sdo_s2_r <= sdo_s1_r;
  end

  // ----------------------------------------------------------------
  // Transfer engine
  // ----------------------------------------------------------------
  dhi_hst_e st_r;
  logic [2:0] strap_r;
  logic [3:0] tmr_r, bits_r;
  logic [SER3_BITS-1:0] tx_r;
  logic [WORD_W-1:0] rx_r, dbo_r;
  logic rd_op_r, dboe_r, par, ser3, fire;
  assign par = !strap_r[2];
  assign ser3 = strap_r == IF_SER3;
  // Parallel bus is shared with the pixel path while RGB runs
  assign O_CMD_READY = st_r == HS_IDLE && tmr_r == '0 && !(par && I_RGB_EN);
  assign fire = O_CMD_READY && I_CMD_VALID;

  always_ff @(posedge I_CLOCK)
  begin
    if (I_RESET)
    begin
      st_r <= HS_IDLE;
      strap_r <= '0;
      tmr_r <= '0;
      bits_r <= '0;
      tx_r <= '0;
      rx_r <= '0;
      dbo_r <= '0;
      dboe_r <= 1'b0;
      rd_op_r <= 1'b0;
      link.hw_reset_in_n <= 1'b1;
      link.chip_select_n <= 1'b1;
      link.data_command_select <= 1'b0;
      link.write_strobe_n <= 1'b1;
      link.read_strobe_n <= 1'b1;
      link.serial_data_in <= 1'b0;
      O_RSP_VALID <= 1'b0;
      O_RSP_DATA <= '0;
    end
    else
    begin
      link.hw_reset_in_n <= I_HW_RESET_N;
      O_RSP_VALID <= 1'b0;
      if (tmr_r != '0)
        tmr_r <= tmr_r - 4'h1;
      unique case (st_r)
        HS_IDLE:
        begin
          strap_r <= I_STRAP;
          if (fire)
          begin
            st_r <= HS_LOW;
            tmr_r <= 4'(BUS_HALF_CYC - 1);
            link.chip_select_n <= 1'b0;
            link.data_command_select <= I_CMD_DC;
            rd_op_r <= I_CMD_READ;
            rx_r <= '0;
            if (par)
            begin
              bits_r <= 4'h1;
              link.read_strobe_n <= !I_CMD_READ;
              link.write_strobe_n <= I_CMD_READ;
              dbo_r <= I_CMD_DATA & width_mask(strap_r);
              dboe_r <= !I_CMD_READ;
            end
            else
            begin
              link.write_strobe_n <= 1'b0;
              bits_r <= (ser3 && !I_CMD_READ) ? 4'(SER3_BITS) : 4'(SER4_BITS);
              tx_r <= I_CMD_READ ? '0 : (ser3 ? {I_CMD_DC, I_CMD_DATA[7:0]}
                : {I_CMD_DATA[7:0], 1'b0});
              link.serial_data_in <= !I_CMD_READ && (ser3 ? I_CMD_DC : I_CMD_DATA[7]);
            end
          end
        end
        HS_LOW:
          if (tmr_r == '0)
          begin
            st_r <= HS_HIGH;
            tmr_r <= 4'(BUS_HALF_CYC - 1);
            bits_r <= bits_r - 4'h1;
            link.write_strobe_n <= 1'b1;
            link.read_strobe_n <= 1'b1;
            tx_r <= {tx_r[SER3_BITS-2:0], 1'b0};
            if (par)
              rx_r <= db_s2_r & width_mask(strap_r);
            else
              rx_r <= {rx_r[WORD_W-2:0], sdo_s2_r};
          end
        HS_HIGH:
          if (tmr_r == '0)
          begin
            tmr_r <= 4'(BUS_HALF_CYC - 1);
            if (!par && bits_r != '0)
            begin
              st_r <= HS_LOW;
              link.write_strobe_n <= 1'b0;
              link.serial_data_in <= tx_r[SER3_BITS-1];
            end
            else
            begin
              st_r <= HS_END;
              link.chip_select_n <= 1'b1;
              dboe_r <= 1'b0;
              O_RSP_VALID <= rd_op_r;
              O_RSP_DATA <= par ? rx_r : WORD_W'(rx_r[SER_W-1:0]);
            end
          end
        HS_END:
          if (tmr_r == '0)
            st_r <= HS_IDLE;
      endcase
    end
  end
  assign {link.iface_strap_bit2, link.iface_strap_bit1, link.iface_strap_bit0} = strap_r;

  // ----------------------------------------------------------------
  // RGB timing generator
  // ----------------------------------------------------------------
  // Free-running while enabled, so clock and line sync never pause
  logic [2:0] pdiv_r;
  logic pclk_r, hs_r, vs_r, de_r;
  logic [9:0] h_r, v_r, h_nxt, v_nxt;
  logic [WORD_W-1:0] pix_r;
  always_comb
  begin
    h_nxt = (h_r == 10'(H_TOT - 1)) ? '0 : h_r + 10'h1;
    v_nxt = v_r;
    if (h_r == 10'(H_TOT - 1))
      v_nxt = (v_r == 10'(V_TOT - 1)) ? '0 : v_r + 10'h1;
  end

  always_ff @(posedge I_CLOCK)
  begin
    if (I_RESET || !I_RGB_EN)
    begin
      pdiv_r <= '0;
      pclk_r <= 1'b0;
      h_r <= 10'(H_TOT - 1);
      v_r <= 10'(V_TOT - 1);
      hs_r <= 1'b1;
      vs_r <= 1'b1;
      de_r <= 1'b0;
      pix_r <= '0;
      O_PIX_TAKEN <= 1'b0;
    end
    else
    begin
      O_PIX_TAKEN <= 1'b0;
      pdiv_r <= pdiv_r + 3'h1;
      if (pdiv_r == 3'(PCLK_HALF_CYC - 1))
      begin
        pdiv_r <= '0;
        pclk_r <= !pclk_r;
        if (pclk_r)
        begin
          h_r <= h_nxt;
          v_r <= v_nxt;
          hs_r <= !(h_nxt < 10'(HS_CLKS));
          vs_r <= !(v_nxt < 10'(VS_LINES));
          de_r <= h_nxt >= 10'(H_DE0) && h_nxt < 10'(H_DE0 + H_ACTIVE)
            && v_nxt >= 10'(V_DE0) && v_nxt < 10'(V_DE0 + V_ACTIVE);
          if (h_nxt >= 10'(H_DE0) && h_nxt < 10'(H_DE0 + H_ACTIVE)
            && v_nxt >= 10'(V_DE0) && v_nxt < 10'(V_DE0 + V_ACTIVE))
          begin
            pix_r <= I_PIX_DATA;
            O_PIX_TAKEN <= 1'b1;
          end
        end
      end
    end
  end
  assign link.pixel_clock_in = pclk_r;
  assign link.hsync_n = hs_r;
  assign link.vsync_n = vs_r;
  assign link.data_enable = de_r;
  assign link.host_db_o = I_RGB_EN ? pix_r : dbo_r;
  assign link.host_db_oe = I_RGB_EN || dboe_r;
endmodule // dhi_host

/* File: dhi_link_chk.sv */
// Link checker: strobe framing, bus turnaround and serial output release.
`timescale 1ns/1ps
module dhi_link_chk (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic chip_select_n,
  input wire logic write_strobe_n,
  input wire logic read_strobe_n,
  input wire logic data_command_select,
  input wire logic host_db_oe,
  input wire logic dev_db_oe,
  input wire logic serial_read_oe
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_reset);
  // ----
  // Properties
  // ----
  // Panel takes the bus a few cycles after the strobe falls, then holds it
  sequence s_dev_drive;
    ##[2:4] dev_db_oe [*4];
  endsequence
  AST_WR_IN_CS: assert property ($fell(write_strobe_n) |-> !chip_select_n)
    else $error("write strobe outside select");
  AST_RD_IN_CS: assert property ($fell(read_strobe_n) |-> !chip_select_n)
    else $error("read strobe outside select");
  AST_NO_FIGHT: assert property (!(host_db_oe && dev_db_oe))
    else $error("both ends drive the bus");
  AST_DEV_OE_CS: assert property (dev_db_oe |-> !chip_select_n)
    else $error("panel drives bus unselected");
  AST_DEV_DRIVE: assert property ($fell(read_strobe_n) |-> s_dev_drive)
    else $error("panel read drive late or short");
  AST_DEV_RELEASE: assert property ($rose(read_strobe_n) |-> ##[1:4] !dev_db_oe)
    else $error("panel holds bus after read");
  AST_SDO_END: assert property ($rose(chip_select_n) |-> ##[0:4] !serial_read_oe)
    else $error("serial output held after select");
  AST_WR_LOW: assert property ($fell(write_strobe_n) |=> !write_strobe_n [*2])
    else $error("write strobe low too short");
  AST_DC_HOLD: assert property ($rose(write_strobe_n) && !chip_select_n
    |-> $stable(data_command_select))
    else $error("select line moved at strobe");
endmodule // dhi_link_chk

/* File: display_host_interface_timing_bench.sv */
// Bench joining the host and panel ends over the pin link.
`timescale 1ns/1ps
module display_host_interface_timing_bench;
  import dhi_pkg::*;
  logic clk = 1'b0, rst = 1'b1, hw_n = 1'b1, cv = 1'b0, crd = 1'b0, cdc = 1'b0;
  logic rgb = 1'b0, awake = 1'b1, srd = 1'b0, wrdy = 1'b1, ovf_seen = 1'b0;
  logic [2:0] strap = 3'h0;
  logic crdy, rv, wv, wdc, ovf, blank, ready, pv, rds, tkn, tkn_seen = 1'b0;
  logic [WORD_W-1:0] cdat = '0, pdat = 18'h2AAAA, rdat = 18'h1C3E7, rsp, wdat, pxo;
  logic [POS_W-1:0] col, row;
  // Serial modes first so the run ends in the widest parallel mode
  logic [2:0] sv [6] = '{3'h5, 3'h7, 3'h1, 3'h2, 3'h3, 3'h0};
  logic [WORD_W-1:0] mv [6] = '{18'h000FF, 18'h000FF, 18'h001FF, 18'h0FFFF, 18'h000FF, 18'h3FFFF};
  int miscompares = 0, n_checks = 0, n_rds = 0, k, j, n;
  always #5 clk = ~clk;
  always @(posedge clk) if (ovf === 1'b1) ovf_seen <= 1'b1;
  always @(posedge clk) if (rds === 1'b1) n_rds <= n_rds + 1;
  always @(posedge clk) if (tkn === 1'b1) tkn_seen <= 1'b1;
  dhi_if link ();
  dhi_host dhi_host_i (.I_CLOCK(clk), .I_RESET(rst), .link(link), .I_STRAP(strap),
    .I_HW_RESET_N(hw_n), .I_CMD_VALID(cv), .O_CMD_READY(crdy), .I_CMD_READ(crd),
    .I_CMD_DC(cdc), .I_CMD_DATA(cdat), .O_RSP_VALID(rv), .O_RSP_DATA(rsp),
    .I_RGB_EN(rgb), .I_PIX_DATA(pdat), .O_PIX_TAKEN(tkn));
  // Blank time outlasts the filtered reset so its tail is visible after release
  dhi_dev #(.LOAD_CYCLES(50), .BLANK_CYCLES(1200)) dhi_dev_i (.I_CLOCK(clk), .I_RESET(rst),
    .link(link), .I_AWAKE(awake), .I_SER_RD(srd), .I_RD_DATA(rdat), .O_RD_STROBE(rds),
    .O_WORD_VALID(wv), .I_WORD_READY(wrdy), .O_WORD_DATA(wdat), .O_WORD_IS_DATA(wdc),
    .O_OVERFLOW(ovf), .O_BLANK(blank), .O_READY(ready), .O_PIX_VALID(pv),
    .O_PIX_DATA(pxo), .O_PIX_COL(col), .O_PIX_ROW(row));
  dhi_link_chk dhi_link_chk_i (.i_clock(clk), .i_reset(rst), .chip_select_n(link.chip_select_n),
    .write_strobe_n(link.write_strobe_n), .read_strobe_n(link.read_strobe_n),
    .data_command_select(link.data_command_select), .host_db_oe(link.host_db_oe),
    .dev_db_oe(link.dev_db_oe), .serial_read_oe(link.serial_read_oe));
  // ----
  // Tasks
  // ----
  task automatic chk(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    if (miscompares == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Samples on the falling edge, away from the bench's own drive edge
  task automatic wait_for(input int s, input int lim);
    n = 0;
    do @(negedge clk);
    while (n++ < lim && (s == 0 ? crdy : s == 1 ? rv : s == 2 ? wv :
      s == 3 ? ready : pv) !== 1'b1);
    if (n > lim)
    begin
      miscompares++;
      $display("wrong value at %0t: wait limit ran out for signal %0d", $time, s);
    end
  endtask
  task automatic cmd(input logic rd, input logic dc, input logic [WORD_W-1:0] d);
    wait_for(0, 500);
    @(posedge clk);
    cv <= 1'b1;
    crd <= rd;
    cdc <= dc;
    cdat <= d;
    @(posedge clk);
    cv <= 1'b0;
  endtask
  task automatic word(input logic [WORD_W-1:0] e, input logic dc);
    wait_for(2, 400);
    chk(18'(wv), 18'h1);
    chk(wdat, e);
    chk(18'(wdc), 18'(dc));
  endtask
  // ----
  // Tests
  // ----
  initial begin
    repeat (40000) @(posedge clk);
    miscompares++;
    print_verdict;
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    wait_for(3, 200);
    for (k = 0; k < 6; k++) begin
      @(posedge clk) strap <= sv[k];
      repeat (20) @(posedge clk);
      for (j = 0; j < 2; j++) begin
        cmd(1'b0, j[0], j[0] ? ~rdat : rdat);
        word((j[0] ? ~rdat : rdat) & mv[k], j[0]);
      end
      @(posedge clk) srd <= 1'b1;
      cmd(1'b1, 1'b1, '0);
      wait_for(1, 400);
      chk(rsp, rdat & mv[k]);
      chk(18'(n_rds), 18'(k + 1));
      @(posedge clk) srd <= 1'b0;
    end
    @(posedge clk) wrdy <= 1'b0;
    for (j = 0; j < 9; j++) cmd(1'b0, 1'b1, 18'(j));
    repeat (40) @(posedge clk);
    @(negedge clk) chk(18'(ovf_seen), 18'h1);
    @(posedge clk) wrdy <= 1'b1;
    for (j = 0; j < 8; j++) word(18'(j), 1'b1);
    @(posedge clk) hw_n <= 1'b0;
    repeat (300) @(posedge clk);
    hw_n <= 1'b1;
    repeat (600) @(posedge clk);
    @(negedge clk) chk(18'(ready), 18'h1);
    @(posedge clk) hw_n <= 1'b0;
    repeat (600) @(posedge clk);
    hw_n <= 1'b1;
    repeat (100) @(posedge clk);
    hw_n <= 1'b0;
    repeat (350) @(posedge clk);
    @(negedge clk) chk(18'({ready, blank}), 18'h1);
    @(posedge clk) hw_n <= 1'b1;
    wait_for(3, 700);
    chk(18'(ready), 18'h1);
    chk(18'(blank), 18'h1);
    repeat (150) @(posedge clk);
    @(negedge clk) chk(18'(blank), 18'h0);
    @(posedge clk) awake <= 1'b0;
    @(posedge clk);
    @(negedge clk) chk(18'(blank), 18'h1);
    @(posedge clk) awake <= 1'b1;
    @(posedge clk) rgb <= 1'b1;
    @(negedge clk) chk(18'(crdy), 18'h0);
    wait_for(4, 30000);
    chk(pxo, pdat);
    chk(18'(tkn_seen), 18'h1);
    chk(18'({col, row}), 18'h0);
    wait_for(4, 20);
    chk(18'({col, row}), 18'h00200);
    print_verdict;
  end
endmodule // display_host_interface_timing_bench
